// file: hdl/sar_adc_sequencer.sv
`timescale 1ns/1ps
`include "sas_map.svh"
module sar_adc_sequencer
  import sas_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // software control bits
  input  wire logic       moduleOnBit,
  input  wire logic       goWrite,
  input  wire logic       goWriteVal,
  input  wire logic [2:0] channelSelectField,
  input  wire logic       referenceSelectBit,
  input  wire logic [2:0] convClockSelectField,
  input  wire logic       resultFormatBit,
  input  wire logic       convIrqEnable,
  input  wire logic       flagClear,
  // system state and trigger
  input  wire logic       sleepMode,
  input  wire logic       specialTrigger,
  // comparator from the analog array
  input  wire logic       cmpAbove,
  // analog front-end controls
  output logic [2:0]      muxChannel,
  output logic            refExternal,
  output logic            sampleEn,
  output logic            analogPowerOn,
  output logic [9:0]      dacCode,
  // status and results
  output logic            goDone,
  output logic            convCompleteFlag,
  output logic            convIrq,
  output logic            wakeRequest,
  output logic            timerClear,
  output logic [7:0]      resultHighReg,
  output logic [7:0]      resultLowReg
);
  sas_state_e state_q;
  sas_state_e state_d;
  logic [3:0] tadCnt_q;
  logic [3:0] tadCnt_d;
  logic [9:0] sar_q;
  logic [9:0] sar_d;
  logic [9:0] result_q;
  logic [2:0] instrCnt_q;
  logic       tadTick;
  logic       isRc;
  logic       poweredOn;
  logic       sleepAbort;
  logic       swAbort;
  logic       startReq;
  logic       convDone;
  logic       rcIdleOff_q;
  logic [3:0] bitIdx;
  logic [9:0] trialBit;
  logic [9:0] decided;
  logic [7:0] fmtHigh;
  logic [7:0] fmtLow;
  logic [9:0] resultNext;
  logic       tickRun;
  logic       goNext;
  logic       flagNext;
  logic       irqNext;
  logic       wakeNext;
  logic       sampleNext;
  logic       rcOffSet;
  logic       rcOffClr;

  assign isRc       = (convClockSelectField[1:0] == 2'b11);
  // rc conversion in sleep without interrupt shuts analog off until wake
  assign poweredOn  = moduleOnBit && !(sleepMode && !isRc) && !rcIdleOff_q;
  assign sleepAbort = sleepMode && !isRc && (state_q != SAS_IDLE);
  assign swAbort    = goWrite && !goWriteVal && (state_q == SAS_CONV || state_q == SAS_DELAY);
  // trigger or software write both set go
  assign startReq   = moduleOnBit && (state_q == SAS_IDLE)
                      && ((goWrite && goWriteVal) || specialTrigger);
  assign convDone   = (state_q == SAS_CONV) && tadTick && (tadCnt_q == `SAS_CONV_TADS - 4'd1);

  // bit under test: msb at period 1, lsb at period 10
  assign bitIdx   = 4'(4'd10 - tadCnt_q);
  assign trialBit = (tadCnt_q >= 4'd1 && tadCnt_q <= 4'd10) ? (10'h001 << bitIdx) : 10'h000;
  assign decided  = cmpAbove ? (sar_q & ~trialBit) : sar_q;

  // new code reaches the result pair on the same edge as the flag
  assign resultNext = convDone ? decided : result_q;
  assign fmtHigh = resultFormatBit ? {6'h00, resultNext[9:8]} : resultNext[9:2];
  assign fmtLow  = resultFormatBit ? resultNext[7:0] : {resultNext[1:0], 6'h00};

  // status decode; the irq term follows the flag's next value
  assign goNext     = (state_d == SAS_DELAY || state_d == SAS_CONV);
  assign flagNext   = convDone || (convCompleteFlag && !flagClear);
  assign irqNext    = convIrqEnable && flagNext;
  assign wakeNext   = convIrqEnable && sleepMode && convDone;
  assign sampleNext = poweredOn && (state_d == SAS_IDLE || state_d == SAS_DELAY);
  assign rcOffSet   = convDone && isRc && sleepMode && !convIrqEnable;
  assign rcOffClr   = !sleepMode || !moduleOnBit;
  // abort restarts the divider so the hold-off spans two whole periods
  assign tickRun    = (state_q == SAS_CONV && state_d != SAS_ABORT) || state_q == SAS_ABORT;

  sas_tick_gen u_tick (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .run     (tickRun),
    .clkSel  (convClockSelectField),
    .tadTick (tadTick)
  );

  always_comb
  begin
    state_d  = state_q;
    tadCnt_d = tadCnt_q;
    sar_d    = sar_q;
    unique case (state_q)
      SAS_IDLE:
        if (startReq)
        begin
          // rc clock waits an instruction so sleep can execute first
          state_d  = isRc ? SAS_DELAY : SAS_CONV;
          tadCnt_d = 4'h0;
          sar_d    = 10'h000;
        end
      SAS_DELAY:
        if (swAbort || !moduleOnBit || sleepAbort)
          state_d = SAS_IDLE;
        else if (instrCnt_q == `SAS_INSTR_CYCLES - 3'd1)
          state_d = SAS_CONV;
      SAS_CONV:
        if (!moduleOnBit || sleepAbort)
          state_d = SAS_IDLE;
        else if (swAbort)
        begin
          state_d  = SAS_ABORT;
          tadCnt_d = 4'h0;
        end
        else if (tadTick)
        begin
          tadCnt_d = tadCnt_q + 4'd1;
          // tentatively set next bit, keep or drop on comparator
          sar_d    = decided | (trialBit >> 1);
          if (tadCnt_q == 4'd0)
            sar_d = 10'h200;
          if (convDone)
            state_d = SAS_IDLE;
        end
      SAS_ABORT:
        if (!moduleOnBit)
          state_d = SAS_IDLE;
        else if (tadTick)
        begin
          tadCnt_d = tadCnt_q + 4'd1;
          if (tadCnt_q == `SAS_ABORT_TADS - 4'd1)
            state_d = SAS_IDLE;
        end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q    <= SAS_IDLE;
      tadCnt_q   <= 4'h0;
      sar_q      <= 10'h000;
      instrCnt_q <= 3'h0;
    end
    else
    begin
      state_q    <= state_d;
      tadCnt_q   <= tadCnt_d;
      sar_q      <= sar_d;
      instrCnt_q <= (state_q == SAS_DELAY) ? 3'(instrCnt_q + 3'd1) : 3'h0;
    end
  end

  // result keeps the previous code across any abort that does not fall on the convDone cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      result_q <= `SAS_RESULT_RST;
    else if (convDone)
      result_q <= decided;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      goDone <= 1'b0;
    else
      goDone <= goNext;
  end

  // set wins over a simultaneous software clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      convCompleteFlag <= 1'b0;
    else
      convCompleteFlag <= flagNext;
  end

  // rc power-down outlives the conversion until sleep ends
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rcIdleOff_q <= 1'b0;
    else if (rcOffSet)
      rcIdleOff_q <= 1'b1;
    else if (rcOffClr)
      rcIdleOff_q <= 1'b0;
  end

  // input routing follows the control bits
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      muxChannel  <= 3'h0;
      refExternal <= 1'b0;
    end
    else
    begin
      muxChannel  <= channelSelectField;
      refExternal <= referenceSelectBit;
    end
  end

  // acquire whenever on and not converting or in abort hold-off
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sampleEn      <= 1'b0;
      analogPowerOn <= 1'b0;
      dacCode       <= 10'h000;
    end
    else
    begin
      sampleEn      <= sampleNext;
      analogPowerOn <= poweredOn;
      dacCode       <= sar_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      convIrq <= 1'b0;
    else
      convIrq <= irqNext;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      wakeRequest <= 1'b0;
    else
      wakeRequest <= wakeNext;
  end

  // a trigger with the module off leaves the timer alone
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      timerClear <= 1'b0;
    else
      timerClear <= specialTrigger && moduleOnBit;
  end

  // format bit acts at once on the stored code
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resultHighReg <= 8'h00;
      resultLowReg  <= 8'h00;
    end
    else
    begin
      resultHighReg <= fmtHigh;
      resultLowReg  <= fmtLow;
    end
  end
endmodule // sar_adc_sequencer

// file: hdl/sas_map.svh
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH
// conversion length in clock periods
`define SAS_CONV_TADS      4'd11
// delay after a software abort, in clock periods
`define SAS_ABORT_TADS     4'd2
// clock select codes
`define SAS_CS_DIV2        3'h0
`define SAS_CS_DIV4        3'h4
`define SAS_CS_DIV8        3'h1
`define SAS_CS_DIV16       3'h5
`define SAS_CS_DIV32       3'h2
`define SAS_CS_DIV64       3'h6
// half-periods in ref_clk cycles for each divider ratio
`define SAS_HALF_DIV2      6'h01
`define SAS_HALF_DIV4      6'h02
`define SAS_HALF_DIV8      6'h04
`define SAS_HALF_DIV16     6'h08
`define SAS_HALF_DIV32     6'h10
`define SAS_HALF_DIV64     6'h20
// rc oscillator modelled as a divider of ref_clk: 4 us at 8 ns
`define SAS_RC_PERIOD_NS   4000
`define SAS_CLK_PERIOD_NS  8
`define SAS_RC_CYCLES      10'((`SAS_RC_PERIOD_NS) / (`SAS_CLK_PERIOD_NS))
// one instruction cycle is four oscillator periods
`define SAS_INSTR_CYCLES   3'h4
`define SAS_RESULT_RST     10'h000
`endif

// file: hdl/sas_pkg.sv
package sas_pkg;
  typedef enum logic [1:0] {
    SAS_IDLE  = 2'b00,
    SAS_DELAY = 2'b01,
    SAS_CONV  = 2'b10,
    SAS_ABORT = 2'b11
  } sas_state_e;
endpackage

// file: hdl/sas_tick_gen.sv
`timescale 1ns/1ps
`include "sas_map.svh"
module sas_tick_gen
  import sas_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       run,
  input  wire logic [2:0] clkSel,
  // one-cycle enable per conversion clock period
  output logic            tadTick
);
  logic [5:0] halfCnt;
  logic [9:0] rcLen;
  logic [9:0] sysLen;
  logic [9:0] periodLen;
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic       isRc;

  assign isRc = (clkSel[1:0] == 2'b11);
  assign halfCnt = (clkSel == `SAS_CS_DIV2)  ? `SAS_HALF_DIV2  :
                   (clkSel == `SAS_CS_DIV4)  ? `SAS_HALF_DIV4  :
                   (clkSel == `SAS_CS_DIV8)  ? `SAS_HALF_DIV8  :
                   (clkSel == `SAS_CS_DIV16) ? `SAS_HALF_DIV16 :
                   (clkSel == `SAS_CS_DIV32) ? `SAS_HALF_DIV32 :
                                               `SAS_HALF_DIV64;
  // system-derived periods track ref_clk; rc period is fixed in time
  assign sysLen    = {3'h0, halfCnt, 1'b0};
  assign rcLen     = `SAS_RC_CYCLES;
  assign periodLen = isRc ? rcLen : sysLen;
  assign cnt_d     = (!run || cnt_q == periodLen - 10'd1) ? 10'h000 : cnt_q + 10'd1;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q   <= 10'h000;
      tadTick <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      tadTick <= run && (cnt_q == periodLen - 10'd1);
    end
  end
endmodule // sas_tick_gen

// file: sim/sas_analog_model.sv
`timescale 1ns/1ps
module sas_analog_model (
  // clock
  input wire logic       ref_clk,
  // front-end controls
  input wire logic [2:0] muxChannel,
  input wire logic       refExternal,
  input wire logic       analogPowerOn,
  input wire logic [9:0] dacCode,
  // comparator
  output logic           cmpAbove
);
  logic       junkQ = 1'h0;
  logic [9:0] level;
  // each channel and reference gives its own level
  // pins are taken as analog inputs only, no digital buffer path
  assign level = {muxChannel, refExternal, 6'h2B};
  always @(posedge ref_clk) junkQ <= ~junkQ;
  // unpowered comparator answers nothing useful
  assign cmpAbove = analogPowerOn ? (dacCode > level) : junkQ;
endmodule // sas_analog_model

// file: sim/sar_adc_sequencer_checker.sv
`timescale 1ns/1ps
module sar_adc_sequencer_checker (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // control
  input wire logic       moduleOnBit,
  input wire logic       goWrite,
  input wire logic       goWriteVal,
  input wire logic       specialTrigger,
  input wire logic       sleepMode,
  input wire logic       flagClear,
  input wire logic       convIrqEnable,
  input wire logic       resultFormatBit,
  input wire logic [2:0] convClockSelectField,
  // status
  input wire logic       goDone,
  input wire logic       convCompleteFlag,
  input wire logic       convIrq,
  input wire logic [7:0] resultHighReg,
  input wire logic [7:0] resultLowReg
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  property p_start;
    $rose(goDone) |-> $past(moduleOnBit && (goWrite && goWriteVal || specialTrigger));
  endproperty
  a_start: assert property (p_start) else $error("busy without start");
  // aborts excluded: software clear, sleep, module off
  property p_done;
    $fell(goDone) && $past(moduleOnBit) && !$past(sleepMode) && !$past(goWrite) |-> convCompleteFlag;
  endproperty
  a_done: assert property (p_done) else $error("finish without flag");
  property p_sticky;
    convCompleteFlag && !flagClear |=> convCompleteFlag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_clear;
    flagClear && !goDone |=> !convCompleteFlag;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_cause;
    $rose(convCompleteFlag) |-> $fell(goDone);
  endproperty
  a_cause: assert property (p_cause) else $error("flag without finish");
  property p_irq;
    convCompleteFlag && convIrqEnable && $past(convCompleteFlag && convIrqEnable) |-> convIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_sleep;
    sleepMode && convClockSelectField[1:0] != 2'h3 && goDone |=> !goDone;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not abort");
  property p_hold;
    !$fell(goDone) && $stable(resultFormatBit) && $past(resultFormatBit) == $past(resultFormatBit, 2)
      |-> $stable(resultHighReg) && $stable(resultLowReg);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed");
  c_done: cover property ($rose(convCompleteFlag));
  c_abort: cover property (goWrite && !goWriteVal && goDone);
  c_trig: cover property (specialTrigger && !goDone);
endmodule // sar_adc_sequencer_checker
bind sar_adc_sequencer sar_adc_sequencer_checker chk (.*);

// file: sim/sar_adc_sequencer_tb_top.sv
`timescale 1ns/1ps
module sar_adc_sequencer_tb_top;
  logic ref_clk = 1'h0, rst_n = 1'h0, moduleOnBit = 1'h0, goWrite = 1'h0, goWriteVal = 1'h0;
  logic referenceSelectBit = 1'h0, resultFormatBit = 1'h0, convIrqEnable = 1'h0, flagClear = 1'h0;
  logic sleepMode = 1'h0, specialTrigger = 1'h0;
  logic [2:0] channelSelectField = 3'h0, convClockSelectField = 3'h0, muxChannel;
  logic cmpAbove, sampleEn, analogPowerOn, refExternal, goDone, convCompleteFlag, convIrq, wakeRequest, timerClear;
  logic [9:0] dacCode;
  logic [7:0] resultHighReg, resultLowReg;
  int errors = 0, tests_run = 0, cnt;
  logic woke;
  logic [9:0] firstTrial;
  // conversion clock period in ref_clk cycles, by select code
  int conv_clock_period [8] = '{2, 8, 32, 500, 4, 16, 64, 500};
  sar_adc_sequencer dut (.*);
  sas_analog_model model (.*);
  initial forever #4 ref_clk = ~ref_clk;
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d, checks %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic go(logic v);
    goWrite <= 1'h1;
    goWriteVal <= v;
    cyc(1);
    goWrite <= 1'h0;
  endtask
  task automatic clr();
    flagClear <= 1'h1;
    cyc(1);
    flagClear <= 1'h0;
    cyc(2);
  endtask
  // counts busy cycles; a wake pulse may trail the finish
  task automatic conv_wait();
    cnt = 0;
    woke = 1'h0;
    firstTrial = 10'h000;
    cyc(1);
    while (goDone === 1'h1 && cnt < 8000)
    begin
      cnt++;
      if (firstTrial == 10'h000)
        firstTrial = dacCode;
      woke |= wakeRequest;
      cyc(1);
    end
    woke |= wakeRequest;
    cyc(1);
    woke |= wakeRequest;
  endtask
  task automatic conv(logic [2:0] cs, logic [2:0] ch, logic fmt, logic slp);
    convClockSelectField <= cs;
    channelSelectField <= ch;
    referenceSelectBit <= ch[0];
    resultFormatBit <= fmt;
    cyc(40);
    go(1'h1);
    sleepMode <= slp;
    conv_wait();
  endtask
  task automatic res(logic [2:0] ch, logic fmt);
    check("result", {resultHighReg, resultLowReg}, fmt ? {6'h00, ch, ch[0], 6'h2B} : {ch, ch[0], 6'h2B, 6'h00});
  endtask
  initial
  begin
    cyc(20);
    rst_n <= 1'h1;
    cyc(2);
    moduleOnBit <= 1'h1;
    for (int i = 0; i < 8; i++)
    begin
      conv(3'(i), 3'(i), i[1], 1'h0);
      check("length", 16'((cnt - 11 * conv_clock_period[i] - ((i & 3) == 3 ? 4 : 0)) inside {[0:2]}), 16'h1);
      check("flag", 16'(convCompleteFlag), 16'h1);
      res(3'(i), i[1]);
      check("mux", {muxChannel, refExternal}, {3'(i), i[0]});
      check("trial", {6'h00, firstTrial}, 16'h0200);
    end
    convIrqEnable <= 1'h1;
    cyc(3);
    check("irq", 16'(convIrq), 16'h1);
    clr();
    check("irq", {convCompleteFlag, convIrq}, 16'h0);
    convIrqEnable <= 1'h0;
    conv(3'h0, 3'h5, 1'h1, 1'h0);
    check("irq", {convCompleteFlag, convIrq}, 16'h2);
    clr();
    convClockSelectField <= 3'h6;
    go(1'h1);
    cyc(100);
    go(1'h0);
    cyc(1);
    go(1'h1);
    cyc(1);
    check("abort", {goDone, convCompleteFlag, sampleEn}, 16'h0);
    res(3'h5, 1'h1);
    cyc(130);
    check("acquire", 16'(sampleEn), 16'h1);
    conv(3'h6, 3'h2, 1'h1, 1'h0);
    res(3'h2, 1'h1);
    moduleOnBit <= 1'h0;
    go(1'h1);
    cyc(2);
    check("off", 16'(goDone), 16'h0);
    moduleOnBit <= 1'h1;
    convClockSelectField <= 3'h1;
    cyc(40);
    go(1'h1);
    cyc(20);
    sleepMode <= 1'h1;
    cyc(2);
    check("sleep", {goDone, analogPowerOn}, 16'h0);
    sleepMode <= 1'h0;
    convIrqEnable <= 1'h1;
    conv(3'h3, 3'h6, 1'h0, 1'h1);
    check("wake", 16'(woke), 16'h1);
    res(3'h6, 1'h0);
    sleepMode <= 1'h0;
    convIrqEnable <= 1'h0;
    clr();
    conv(3'h7, 3'h1, 1'h0, 1'h1);
    check("rc", {analogPowerOn, convCompleteFlag}, 16'h1);
    sleepMode <= 1'h0;
    convClockSelectField <= 3'h0;
    cyc(40);
    specialTrigger <= 1'h1;
    cyc(1);
    specialTrigger <= 1'h0;
    cyc(1);
    check("trigger", {timerClear, goDone}, 16'h3);
    conv_wait();
    res(3'h1, 1'h0);
    check("trigger", 16'(timerClear), 16'h0);
    convClockSelectField <= 3'h6;
    go(1'h1);
    cyc(10);
    rst_n <= 1'h0;
    cyc(2);
    check("reset", {resultHighReg, resultLowReg}, 16'h0);
    check("reset", {goDone, convCompleteFlag, analogPowerOn, sampleEn}, 16'h0);
    end_of_test();
  end
  initial
  begin
    cyc(60000);
    errors++;
    end_of_test();
  end
endmodule // sar_adc_sequencer_tb_top
